// ### rtl/table_move_pkg.sv
// Shared constants and types for the table pointer move unit.
package table_move_pkg;

    // Word memory geometry.
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int LEN_W = 8;
    localparam int MEM_WORDS = 1024;

    // Result word layout: flag, moved, pointer.
    localparam int RES_W = 18;
    localparam int RES_FLAG_BIT = 17;
    localparam int RES_MOVED_BIT = 16;

    // Pointer values with a fixed meaning.
    localparam logic [15:0] PTR_ZERO = 16'h0000;
    localparam logic [15:0] PTR_ONE = 16'h0001;

    // Reset values.
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [9:0] ADDR_RESET = 10'h000;
    localparam logic [7:0] LEN_RESET = 8'h00;
    localparam logic [17:0] RES_RESET = 18'h00000;

    // Table operations.
    typedef enum logic {
        OP_REMOVE_FROM_BOTTOM,
        OP_SOURCE_TO_TABLE
    } op_t;

    // Execution states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MOVE,
        ST_POINTER,
        ST_REPORT
    } state_t;

endpackage : table_move_pkg

// ### rtl/result_buffer.sv
// Two-entry valid/ready buffer carrying execution results.
`timescale 1ns/1ps
module result_buffer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [table_move_pkg::RES_W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [table_move_pkg::RES_W-1:0] out_data
);

    typedef struct packed {
        logic [table_move_pkg::RES_W-1:0] e0;
        logic [table_move_pkg::RES_W-1:0] e1;
        logic v0;
        logic v1;
        logic rdy;
    } buf_t;

    localparam buf_t BUF_RESET = '{
        e0: table_move_pkg::RES_RESET,
        e1: table_move_pkg::RES_RESET,
        v0: 1'b0,
        v1: 1'b0,
        rdy: 1'b1
    };

    buf_t q;
    buf_t d;

    // Head shifts out on a drain, a new word fills the first free slot.
    always_comb begin
        d = q;
        if (q.v0 && out_ready) begin
            d.e0 = q.e1;
            d.v0 = q.v1;
            d.v1 = 1'b0;
        end
        if (in_valid && q.rdy) begin
            if (!d.v0) begin
                d.e0 = in_data;
                d.v0 = 1'b1;
            end else begin
                d.e1 = in_data;
                d.v1 = 1'b1;
            end
        end
        d.rdy = !d.v1;
    end

    // State register.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            q <= BUF_RESET;
        end else begin
            q <= d;
        end
    end

    // Outputs come straight from the state flops.
    assign in_ready = q.rdy;
    assign out_valid = q.v0;
    assign out_data = q.e0;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    buffer_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("Stalled result changed or vanished.");

endmodule : result_buffer

// ### rtl/table_pointer_move_unit.sv
// Table move unit: remove-from-bottom and source-to-table on a word memory.
// Function
// - Remove copies pointed word, then decrements pointer
// - First table word is the pointer
// - Executes once per issued command each scan
// - Remove stops at pointer zero
// - Remove writes removed word to destination
// - Remove sets flag when pointer is zero
// - Flag valid until reuse or scan end
// - Pointer k selects start plus k
// - Source copied into table, pointer incremented
// - Source word operand is read
// - Pointer at length wraps to one
// - Pointer zero or length writes first word
// - Pointer beyond length moves nothing
// - Source flag set when pointer equals length
`timescale 1ns/1ps
module table_pointer_move_unit (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Command from the controlling program
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire table_move_pkg::op_t cmd_op,
    input wire logic [table_move_pkg::LEN_W-1:0] cmd_length,
    input wire logic [table_move_pkg::ADDR_W-1:0] cmd_start,
    input wire logic [table_move_pkg::ADDR_W-1:0] cmd_operand,
    // Scan boundary
    input wire logic scan_end,
    // Program access to the word memory
    input wire logic mem_req,
    output logic mem_ready,
    input wire logic mem_we,
    input wire logic [table_move_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [table_move_pkg::DATA_W-1:0] mem_wdata,
    output logic [table_move_pkg::DATA_W-1:0] mem_rdata,
    // Status
    output logic table_pointer_flag,
    // Result stream
    output logic res_valid,
    input wire logic res_ready,
    output logic res_flag,
    output logic res_moved,
    output logic [table_move_pkg::DATA_W-1:0] res_pointer
);

    typedef struct packed {
        table_move_pkg::state_t st;
        table_move_pkg::op_t op;
        logic [table_move_pkg::LEN_W-1:0] len;
        logic [table_move_pkg::ADDR_W-1:0] start;
        logic [table_move_pkg::ADDR_W-1:0] operand;
        logic [table_move_pkg::DATA_W-1:0] ptr;
        logic moved;
        logic flag;
        logic tflag;
        logic cmd_rdy;
        logic mem_rdy;
        logic [table_move_pkg::DATA_W-1:0] rdata;
        logic push;
    } core_t;

    localparam core_t CORE_RESET = '{
        st: table_move_pkg::ST_IDLE,
        op: table_move_pkg::OP_REMOVE_FROM_BOTTOM,
        len: table_move_pkg::LEN_RESET,
        start: table_move_pkg::ADDR_RESET,
        operand: table_move_pkg::ADDR_RESET,
        ptr: table_move_pkg::WORD_RESET,
        moved: 1'b0,
        flag: 1'b0,
        tflag: 1'b0,
        cmd_rdy: 1'b1,
        mem_rdy: 1'b1,
        rdata: table_move_pkg::WORD_RESET,
        push: 1'b0
    };

    // Address of table slot off words past the pointer word.
    function automatic logic [table_move_pkg::ADDR_W-1:0] slot_addr(
        input logic [table_move_pkg::ADDR_W-1:0] base,
        input logic [table_move_pkg::DATA_W-1:0] off
    );
        slot_addr = base + off[table_move_pkg::ADDR_W-1:0];
    endfunction : slot_addr

    logic [table_move_pkg::DATA_W-1:0] words [table_move_pkg::MEM_WORDS];
    core_t q;
    core_t d;
    logic wr_en;
    logic [table_move_pkg::ADDR_W-1:0] wr_addr;
    logic [table_move_pkg::DATA_W-1:0] wr_data;
    logic [table_move_pkg::DATA_W-1:0] ptr_word;
    logic [table_move_pkg::DATA_W-1:0] src_word;
    logic [table_move_pkg::DATA_W-1:0] len_word;
    logic buf_in_ready;
    logic [table_move_pkg::RES_W-1:0] buf_out;

    // Next-state logic: memory port, execution sequence and status flag.
    always_comb begin
        d = q;
        wr_en = 1'b0;
        wr_addr = table_move_pkg::ADDR_RESET;
        wr_data = table_move_pkg::WORD_RESET;
        ptr_word = words[q.start];
        src_word = words[q.operand];
        len_word = {8'h00, q.len};
        // Scan end drops the flag unless an execution sets it now.
        if (scan_end) begin
            d.tflag = 1'b0;
        end
        // Program access is taken only while no execution runs.
        if (mem_req && q.mem_rdy) begin
            if (mem_we) begin
                wr_en = 1'b1;
                wr_addr = mem_addr;
                wr_data = mem_wdata;
            end else begin
                d.rdata = words[mem_addr];
            end
        end
        case (q.st)
            table_move_pkg::ST_IDLE: begin
                if (cmd_valid && q.cmd_rdy) begin
                    d.op = cmd_op;
                    d.len = cmd_length;
                    d.start = cmd_start;
                    d.operand = cmd_operand;
                    d.st = table_move_pkg::ST_MOVE;
                end
            end
            table_move_pkg::ST_MOVE: begin
                if (q.op == table_move_pkg::OP_REMOVE_FROM_BOTTOM) begin
                    if (ptr_word != table_move_pkg::PTR_ZERO) begin
                        wr_en = 1'b1;
                        wr_addr = q.operand;
                        wr_data = words[slot_addr(q.start, ptr_word)];
                        d.ptr = ptr_word - table_move_pkg::PTR_ONE;
                        d.moved = 1'b1;
                    end else begin
                        d.ptr = ptr_word;
                        d.moved = 1'b0;
                    end
                    d.flag = (d.ptr == table_move_pkg::PTR_ZERO);
                end else begin
                    if (ptr_word > len_word) begin
                        d.ptr = ptr_word;
                        d.moved = 1'b0;
                    end else begin
                        // Zero and length both land in the first data word.
                        if (ptr_word == len_word) begin
                            d.ptr = table_move_pkg::PTR_ONE;
                        end else begin
                            d.ptr = ptr_word + table_move_pkg::PTR_ONE;
                        end
                        wr_en = 1'b1;
                        wr_addr = slot_addr(q.start, d.ptr);
                        wr_data = src_word;
                        d.moved = 1'b1;
                    end
                    d.flag = (d.ptr == len_word);
                end
                d.st = table_move_pkg::ST_POINTER;
            end
            table_move_pkg::ST_POINTER: begin
                // Pointer write back closes the execution.
                if (q.moved) begin
                    wr_en = 1'b1;
                    wr_addr = q.start;
                    wr_data = q.ptr;
                end
                d.tflag = q.flag;
                d.push = 1'b1;
                d.st = table_move_pkg::ST_REPORT;
            end
            table_move_pkg::ST_REPORT: begin
                // A full result buffer stalls here and holds off commands.
                if (buf_in_ready) begin
                    d.push = 1'b0;
                    d.st = table_move_pkg::ST_IDLE;
                end
            end
            default: begin
                d.st = table_move_pkg::ST_IDLE;
            end
        endcase
        d.cmd_rdy = (d.st == table_move_pkg::ST_IDLE);
        d.mem_rdy = (d.st == table_move_pkg::ST_IDLE);
    end

    // State register.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            q <= CORE_RESET;
        end else begin
            q <= d;
        end
    end

    // Word memory write port.
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            words[wr_addr] <= wr_data;
        end
    end

    // Results pass a two-entry buffer so a stalled reader loses nothing.
    result_buffer u_result_buffer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .in_valid(q.push),
        .in_ready(buf_in_ready),
        .in_data({q.flag, q.moved, q.ptr}),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(buf_out)
    );

    // Outputs, each taken from a flop.
    assign cmd_ready = q.cmd_rdy;
    assign mem_ready = q.mem_rdy;
    assign mem_rdata = q.rdata;
    assign table_pointer_flag = q.tflag;
    assign res_flag = buf_out[table_move_pkg::RES_FLAG_BIT];
    assign res_moved = buf_out[table_move_pkg::RES_MOVED_BIT];
    assign res_pointer = buf_out[table_move_pkg::DATA_W-1:0];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic in_move;
    logic is_remove;
    assign in_move = (q.st == table_move_pkg::ST_MOVE);
    assign is_remove = (q.op == table_move_pkg::OP_REMOVE_FROM_BOTTOM);

    // Execution steps after a command is taken.
    sequence take_s;
        cmd_valid && cmd_ready;
    endsequence
    sequence run_s;
        (q.st == table_move_pkg::ST_MOVE) ##1 (q.st == table_move_pkg::ST_POINTER)
            ##1 (q.st == table_move_pkg::ST_REPORT);
    endsequence

    exec_order_a: assert property (take_s |=> run_s)
        else $error("Execution did not run move, pointer, report.");

    single_exec_a: assert property (take_s |=> !cmd_ready [*3])
        else $error("Command taken again during an execution.");

    remove_step_a: assert property (in_move && is_remove && ptr_word != table_move_pkg::PTR_ZERO
        |=> (q.ptr == $past(ptr_word) - table_move_pkg::PTR_ONE) ##1 (ptr_word == q.ptr))
        else $error("Remove did not decrement and store the pointer.");

    remove_stop_a: assert property (in_move && is_remove && ptr_word == table_move_pkg::PTR_ZERO
        |-> !wr_en ##1 (!wr_en && q.ptr == table_move_pkg::PTR_ZERO))
        else $error("Remove acted on a zero pointer.");

    remove_flag_a: assert property ((q.st == table_move_pkg::ST_POINTER) && is_remove
        |=> table_pointer_flag == (q.ptr == table_move_pkg::PTR_ZERO))
        else $error("Remove flag does not match a zero pointer.");

    source_flag_a: assert property ((q.st == table_move_pkg::ST_POINTER) && !is_remove
        |=> table_pointer_flag == (q.ptr == len_word))
        else $error("Source flag does not match pointer at length.");

    source_wrap_a: assert property (in_move && !is_remove && ptr_word == len_word
        |=> q.ptr == table_move_pkg::PTR_ONE ##1 ptr_word == table_move_pkg::PTR_ONE)
        else $error("Source pointer did not wrap to one.");

    source_first_a: assert property (in_move && !is_remove
        && (ptr_word == table_move_pkg::PTR_ZERO || ptr_word == len_word)
        |=> words[slot_addr(q.start, table_move_pkg::PTR_ONE)] == $past(src_word))
        else $error("Source did not land in the first data word.");

    source_range_a: assert property (in_move && !is_remove && ptr_word > len_word
        |-> !wr_en ##1 !wr_en)
        else $error("Source moved data with pointer beyond length.");

    flag_clear_a: assert property (scan_end && q.st != table_move_pkg::ST_POINTER
        |=> !table_pointer_flag)
        else $error("Flag survived the end of the scan.");

endmodule : table_pointer_move_unit

// ### sim/test_table_pointer_move_unit.sv
// Self-checking testbench for the table pointer move unit.
`timescale 1ns/1ps
module test_table_pointer_move_unit;
    logic ref_clk, resetn, cmd_valid, cmd_ready, scan_end, mem_req, mem_ready, mem_we;
    logic table_pointer_flag, res_valid, res_ready, res_flag, res_moved;
    table_move_pkg::op_t cmd_op;
    logic [table_move_pkg::LEN_W-1:0] cmd_length;
    logic [table_move_pkg::ADDR_W-1:0] cmd_start, cmd_operand, mem_addr;
    logic [table_move_pkg::DATA_W-1:0] mem_wdata, mem_rdata, res_pointer;
    int mismatches = 0;
    int num_checks = 0;

    // Unit under test.
    table_pointer_move_unit i_dut (
        .ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_length(cmd_length), .cmd_start(cmd_start),
        .cmd_operand(cmd_operand), .scan_end(scan_end), .mem_req(mem_req),
        .mem_ready(mem_ready), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .table_pointer_flag(table_pointer_flag),
        .res_valid(res_valid), .res_ready(res_ready), .res_flag(res_flag),
        .res_moved(res_moved), .res_pointer(res_pointer)
    );

    // Clock of 5 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Counts one comparison and reports a difference at once.
    task automatic check(input logic [17:0] seen, input logic [17:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // One memory access held until taken; read data is picked up a cycle later.
    task automatic mem_access(input logic we, input logic [9:0] addr, input logic [15:0] wd,
        output logic [15:0] rd);
        int n;
        @(posedge ref_clk);
        mem_req <= 1'b1;
        mem_we <= we;
        mem_addr <= addr;
        mem_wdata <= wd;
        for (n = 0; n < 30; n++) begin
            @(posedge ref_clk);
            if (mem_ready === 1'b1) break;
        end
        mem_req <= 1'b0;
        @(posedge ref_clk);
        rd = mem_rdata;
    endtask : mem_access

    // Offers one command and holds it until it is taken.
    task automatic issue(input table_move_pkg::op_t op, input logic [7:0] len,
        input logic [9:0] start, input logic [9:0] oper);
        int n;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_length <= len;
        cmd_start <= start;
        cmd_operand <= oper;
        for (n = 0; n < 30; n++) begin
            @(posedge ref_clk);
            if (cmd_ready === 1'b1) break;
        end
        cmd_valid <= 1'b0;
        check(18'(n < 30), 18'h00001, "command taken");
    endtask : issue

    // Runs one command and returns its result and the status flag.
    task automatic exec(input table_move_pkg::op_t op, input logic [7:0] len,
        input logic [9:0] start, input logic [9:0] oper,
        output logic moved, output logic [15:0] ptr, output logic flag, output logic sflag);
        int n;
        issue(op, len, start, oper);
        moved = 1'bx;
        ptr = 16'hXXXX;
        flag = 1'bx;
        sflag = 1'bx;
        for (n = 0; n < 30; n++) begin
            @(posedge ref_clk);
            if (res_valid === 1'b1) begin
                moved = res_moved;
                ptr = res_pointer;
                flag = res_flag;
                sflag = table_pointer_flag;
                break;
            end
        end
    endtask : exec

    // Remove walks the pointer down to zero, then stops; scan end clears the flag.
    task automatic test_remove();
        logic m, f, s;
        logic [15:0] p, w, e;
        int k;
        mem_access(1'b1, 10'h100, 16'h0003, w);
        for (k = 1; k <= 3; k++) mem_access(1'b1, 10'h100 + 10'(k), 16'hA000 + 16'(k), w);
        for (k = 3; k >= 0; k--) begin
            e = (k == 0) ? 16'h0000 : 16'(k - 1);
            exec(table_move_pkg::OP_REMOVE_FROM_BOTTOM, 8'h06, 10'h100, 10'h200, m, p, f, s);
            check(18'(m), 18'(k != 0), "remove moved");
            check(18'(p), 18'(e), "remove pointer");
            check(18'(f), 18'(e == 0), "remove result flag");
            check(18'(s), 18'(e == 0), "remove status flag");
            mem_access(1'b0, 10'h200, 16'h0000, w);
            check(18'(w), 18'(16'hA000 + 16'((k == 0) ? 1 : k)), "remove data");
            mem_access(1'b0, 10'h100, 16'h0000, w);
            check(18'(w), 18'(e), "remove pointer word");
        end
        @(posedge ref_clk);
        scan_end <= 1'b1;
        @(posedge ref_clk);
        scan_end <= 1'b0;
        @(posedge ref_clk);
        check(18'(table_pointer_flag), 18'h00000, "flag after scan end");
        $display("test remove done");
    endtask : test_remove

    // Source fills the table, wraps to one, and refuses a pointer beyond length.
    task automatic test_source();
        logic m, f, s;
        logic [15:0] p, w, e;
        int k;
        mem_access(1'b1, 10'h300, 16'h0000, w);
        for (k = 0; k < 5; k++) begin
            e = 16'((k % 3) + 1);
            mem_access(1'b1, 10'h380, 16'hB000 + 16'(k), w);
            exec(table_move_pkg::OP_SOURCE_TO_TABLE, 8'h03, 10'h300, 10'h380, m, p, f, s);
            check(18'(m), 18'h00001, "source moved");
            check(18'(p), 18'(e), "source pointer");
            check(18'(s), 18'(e == 3), "source status flag");
            check(18'(f), 18'(e == 3), "source result flag");
            mem_access(1'b0, 10'h300 + 10'(e), 16'h0000, w);
            check(18'(w), 18'(16'hB000 + 16'(k)), "source data");
            mem_access(1'b0, 10'h300, 16'h0000, w);
            check(18'(w), 18'(e), "source pointer word");
        end
        mem_access(1'b1, 10'h300, 16'h0005, w);
        exec(table_move_pkg::OP_SOURCE_TO_TABLE, 8'h03, 10'h300, 10'h380, m, p, f, s);
        check(18'(m), 18'h00000, "out of range moved");
        check(18'(p), 18'h00005, "out of range pointer");
        mem_access(1'b0, 10'h301, 16'h0000, w);
        check(18'(w), 18'h0B003, "out of range data");
        $display("test source done");
    endtask : test_source

    // A stalled reader fills the result buffer; three commands give three results.
    task automatic test_buffer();
        logic [15:0] w;
        int k, n;
        mem_access(1'b1, 10'h300, 16'h0000, w);
        res_ready <= 1'b0;
        for (k = 0; k < 3; k++) issue(table_move_pkg::OP_SOURCE_TO_TABLE, 8'h08, 10'h300, 10'h380);
        repeat (8) @(posedge ref_clk);
        check(18'(cmd_ready), 18'h00000, "stalled while buffer full");
        check(18'(mem_ready), 18'h00000, "memory refused while stalled");
        res_ready <= 1'b1;
        n = 0;
        for (k = 0; k < 40 && n < 3; k++) begin
            @(posedge ref_clk);
            if (res_valid === 1'b1) begin
                n++;
                check(18'(res_pointer), 18'(n), "drained pointer");
            end
        end
        check(18'(n), 18'h00003, "drained count");
        $display("test buffer done");
    endtask : test_buffer

    // Cuts a hung run short.
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end

    // Reset, then the scenarios.
    initial begin
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = table_move_pkg::OP_REMOVE_FROM_BOTTOM;
        cmd_length = 8'h00;
        cmd_start = 10'h000;
        cmd_operand = 10'h000;
        scan_end = 1'b0;
        mem_req = 1'b0;
        mem_we = 1'b0;
        mem_addr = 10'h000;
        mem_wdata = 16'h0000;
        res_ready = 1'b1;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        check(18'(cmd_ready), 18'h00001, "ready after reset");
        check(18'(res_valid), 18'h00000, "no result after reset");
        test_remove();
        test_source();
        test_buffer();
        print_verdict();
    end
endmodule : test_table_pointer_move_unit
